//--- rtl/sbmd_pkg.sv
// shared constants, types and decode helpers for the scan buffer mode decoder
package sbmd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // apb register map, byte addresses of aligned 32-bit words
    localparam int unsigned APB_AW = 8;
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_COUNT = 8'h0c;
    localparam logic [7:0] OFF_DATA = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // scan configuration word layout
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam int unsigned CFG_MODE_HI = 15;
    localparam int unsigned CFG_MODE_LO = 11;
    localparam int unsigned CFG_OPT_BIT = 10;
    localparam int unsigned CFG_GAIN_HI = 9;
    localparam int unsigned CFG_GAIN_LO = 8;
    localparam int unsigned CFG_SPEED_HI = 7;
    localparam int unsigned CFG_SPEED_LO = 6;
    localparam int unsigned CFG_CH_HI = 5;

    // control register layout
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_ABORT_BIT = 1;
    localparam int unsigned CTRL_VAR_LO = 8;
    localparam int unsigned CTRL_VAR_HI = 9;

    // status and data register layout
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_MODE_ERR_BIT = 2;
    localparam int unsigned ST_GRP_ERR_BIT = 3;
    localparam int unsigned ST_DEPTH_LO = 4;
    localparam int unsigned ST_BLK_LO = 8;
    localparam int unsigned ST_FIRST_LO = 16;
    localparam int unsigned ST_LEVEL_LO = 24;
    localparam int unsigned DATA_CH_LO = 16;
    localparam int unsigned DATA_VALID_BIT = 31;

    // sample fifo shape
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_LW = 5;
    localparam logic [4:0] FIFO_STOP_LEVEL = 5'h0f;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {
        BLK_1 = 3'b000,
        BLK_8 = 3'b001,
        BLK_16 = 3'b010,
        BLK_32 = 3'b011,
        BLK_64 = 3'b100
    } sbmd_blk_t;

    typedef enum logic [1:0] {
        VAR_16 = 2'b00,
        VAR_32 = 2'b01,
        VAR_64 = 2'b10
    } sbmd_variant_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SCAN = 1'b1
    } sbmd_state_t;

    typedef struct packed {
        logic ok;
        logic [3:0] depth_log2;
        sbmd_blk_t blk;
    } sbmd_mode_t;

    typedef struct packed {
        logic [5:0] channel;
        logic [15:0] data;
    } sbmd_sample_t;

    localparam int unsigned SAMPLE_W = $bits(sbmd_sample_t);
    localparam sbmd_variant_t VAR_RESET = VAR_64;

    // channels spanned by each block size
    localparam logic [6:0] SPAN_1 = 7'h01;
    localparam logic [6:0] SPAN_8 = 7'h08;
    localparam logic [6:0] SPAN_16 = 7'h10;
    localparam logic [6:0] SPAN_32 = 7'h20;
    localparam logic [6:0] SPAN_64 = 7'h40;

    // highest channel fitted on each board variant
    localparam logic [5:0] MAX_CH_16 = 6'h0f;
    localparam logic [5:0] MAX_CH_32 = 6'h1f;
    localparam logic [5:0] MAX_CH_64 = 6'h3f;

    ////////////////////////////////////////////////////////////////////////
    // mode table, indexed by bits 15..11: {ok, log2 depth, block size}
    localparam logic [7:0] MODE_TABLE [0:31] = '{
        8'h00, 8'h00, 8'h00, 8'ha8, 8'ha9, 8'haa, 8'hab, 8'hb0,
        8'hb1, 8'hb2, 8'hb3, 8'hb4, 8'hb8, 8'hb9, 8'hba, 8'hbb,
        8'hbc, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc8, 8'hc9,
        8'hca, 8'hcb, 8'hcc, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4
    };

    // codes 00000..00010 hold all-zero entries and decode as not ok
    function automatic sbmd_mode_t sbmd_decode(input logic [4:0] code);
        return sbmd_mode_t'(MODE_TABLE[code]);
    endfunction : sbmd_decode

    // lowest channel of the selected group
    function automatic logic [5:0] sbmd_first_ch(input logic [5:0] low, input sbmd_blk_t blk);
        case (blk)
            BLK_8: return {low[2:0], 3'h0};
            BLK_16: return {low[2:1], 4'h0};
            BLK_32: return {low[2], 5'h00};
            BLK_64: return 6'h00;
            default: return low;
        endcase
    endfunction : sbmd_first_ch

    function automatic logic [6:0] sbmd_span(input sbmd_blk_t blk);
        case (blk)
            BLK_8: return SPAN_8;
            BLK_16: return SPAN_16;
            BLK_32: return SPAN_32;
            BLK_64: return SPAN_64;
            default: return SPAN_1;
        endcase
    endfunction : sbmd_span

    function automatic logic [5:0] sbmd_max_ch(input sbmd_variant_t v);
        case (v)
            VAR_16: return MAX_CH_16;
            VAR_32: return MAX_CH_32;
            default: return MAX_CH_64;
        endcase
    endfunction : sbmd_max_ch

endpackage : sbmd_pkg

//--- rtl/sbmd_fifo.sv
// parameterised first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sbmd_fifo #(
    parameter int unsigned WIDTH = 22,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned LW = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // occupancy
    output logic [LW-1:0] level
);

    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    // handshakes; depth is a power of two so pointers wrap naturally
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr];

    // storage carries no reset, only the pointers and the level do
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            level <= LW'(level + LW'(push) - LW'(pop));
        end
    end

endmodule : sbmd_fifo

`default_nettype wire

//--- rtl/sbmd_top.sv
// scan configuration decoder and sample collector behind an apb slave
`timescale 1ns/1ps
`default_nettype none

module sbmd_top (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    // sample stream from the converter, same clock
    input wire logic SAMPLE_VALID,
    input wire logic [15:0] SAMPLE_DATA,
    output logic SAMPLE_READY,
    output logic [5:0] SCAN_CHANNEL,
    output logic SCAN_ACTIVE,
    output logic SCAN_DONE,
    // configuration fields for the analog front end
    output logic CFG_OPTION,
    output logic [1:0] CFG_GAIN_LIKE_FIELD,
    output logic [1:0] CFG_SPEED
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // software visible registers
    logic [15:0] cfg_word;
    sbmd_pkg::sbmd_variant_t variant;

    // scan sequencer state
    sbmd_pkg::sbmd_state_t state;
    logic [5:0] run_first;
    logic [5:0] run_last;
    logic [10:0] run_words;
    logic [10:0] word_cnt;
    logic mode_err;
    logic grp_err;

    // apb decode
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic known;
    logic [31:0] next_rdata;

    // control strobes
    logic start_req;
    logic abort_req;

    // decode of the current configuration word
    sbmd_pkg::sbmd_mode_t cur_mode;
    logic [5:0] cur_first;
    logic [6:0] cur_last;
    logic cur_fits;
    logic start_ok;

    // sample path
    logic accept;
    logic finishing;
    logic next_scan;
    sbmd_pkg::sbmd_sample_t push_word;
    sbmd_pkg::sbmd_sample_t head_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [sbmd_pkg::FIFO_LW-1:0] fifo_level;

    ////////////////////////////////////////////////////////////////////////
    // apb access phase
    // one wait state: the answer is registered so prdata comes from a flop

    assign access = PSEL && PENABLE && !PREADY;
    assign wr_fire = access && PWRITE;
    assign rd_fire = access && !PWRITE;

    // address decode; unmapped addresses answer with an error
    always_comb begin
        known = 1'b0;
        if (PADDR == sbmd_pkg::OFF_CFG) begin
            known = 1'b1;
        end else if (PADDR == sbmd_pkg::OFF_CTRL) begin
            known = 1'b1;
        end else if (PADDR == sbmd_pkg::OFF_STATUS) begin
            known = 1'b1;
        end else if (PADDR == sbmd_pkg::OFF_COUNT) begin
            known = 1'b1;
        end else if (PADDR == sbmd_pkg::OFF_DATA) begin
            known = 1'b1;
        end
    end

    // read data multiplexer
    always_comb begin
        next_rdata = '0;
        if (PADDR == sbmd_pkg::OFF_CFG) begin
            next_rdata[15:0] = cfg_word;
        end else if (PADDR == sbmd_pkg::OFF_CTRL) begin
            next_rdata[sbmd_pkg::CTRL_VAR_HI:sbmd_pkg::CTRL_VAR_LO] = variant;
        end else if (PADDR == sbmd_pkg::OFF_STATUS) begin
            next_rdata[sbmd_pkg::ST_BUSY_BIT] = (state == sbmd_pkg::ST_SCAN);
            next_rdata[sbmd_pkg::ST_DONE_BIT] = SCAN_DONE;
            next_rdata[sbmd_pkg::ST_MODE_ERR_BIT] = mode_err;
            next_rdata[sbmd_pkg::ST_GRP_ERR_BIT] = grp_err;
            next_rdata[sbmd_pkg::ST_DEPTH_LO +: 4] = cur_mode.depth_log2;
            next_rdata[sbmd_pkg::ST_BLK_LO +: 3] = cur_mode.blk;
            next_rdata[sbmd_pkg::ST_FIRST_LO +: 6] = cur_first;
            next_rdata[sbmd_pkg::ST_LEVEL_LO +: sbmd_pkg::FIFO_LW] = fifo_level;
        end else if (PADDR == sbmd_pkg::OFF_COUNT) begin
            next_rdata[10:0] = word_cnt;
        end else if (PADDR == sbmd_pkg::OFF_DATA) begin
            next_rdata[sbmd_pkg::DATA_VALID_BIT] = fifo_out_valid;
            next_rdata[sbmd_pkg::DATA_CH_LO +: 6] = head_word.channel;
            next_rdata[15:0] = head_word.data;
        end
    end

    // registered answer, held one cycle
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= access;
            PSLVERR <= access && !known;
            if (rd_fire) begin
                PRDATA <= next_rdata;
            end
        end
    end

    // reading the data word takes the head sample out of the buffer
    assign fifo_pop = rd_fire && (PADDR == sbmd_pkg::OFF_DATA) && fifo_out_valid;

    ////////////////////////////////////////////////////////////////////////
    // configuration and control registers

    // the configuration word may be rewritten at any time; a scan keeps
    // the settings it latched at start, so a late write cannot tear it
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_word <= sbmd_pkg::CFG_RESET;
        end else if (wr_fire && (PADDR == sbmd_pkg::OFF_CFG)) begin
            cfg_word <= PWDATA[15:0];
        end
    end

    // board variant selects which channel groups exist
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            variant <= sbmd_pkg::VAR_RESET;
        end else if (wr_fire && (PADDR == sbmd_pkg::OFF_CTRL)) begin
            variant <= sbmd_pkg::sbmd_variant_t'(PWDATA[sbmd_pkg::CTRL_VAR_HI:sbmd_pkg::CTRL_VAR_LO]);
        end
    end

    // start and abort are write-one strobes in the control word
    assign start_req = wr_fire && (PADDR == sbmd_pkg::OFF_CTRL) && PWDATA[sbmd_pkg::CTRL_START_BIT];
    assign abort_req = wr_fire && (PADDR == sbmd_pkg::OFF_CTRL) && PWDATA[sbmd_pkg::CTRL_ABORT_BIT];

    // gain, option and speed bits go out untouched in every mode
    assign CFG_OPTION = cfg_word[sbmd_pkg::CFG_OPT_BIT];
    assign CFG_GAIN_LIKE_FIELD = cfg_word[sbmd_pkg::CFG_GAIN_HI:sbmd_pkg::CFG_GAIN_LO];
    assign CFG_SPEED = cfg_word[sbmd_pkg::CFG_SPEED_HI:sbmd_pkg::CFG_SPEED_LO];

    ////////////////////////////////////////////////////////////////////////
    // mode decode

    // upper five bits pick buffer depth and grouping
    assign cur_mode = sbmd_pkg::sbmd_decode(cfg_word[sbmd_pkg::CFG_MODE_HI:sbmd_pkg::CFG_MODE_LO]);

    // low bits pick the group; unused bits of each grouping are ignored
    assign cur_first = sbmd_pkg::sbmd_first_ch(cfg_word[sbmd_pkg::CFG_CH_HI:0], cur_mode.blk);
    assign cur_last = 7'({1'b0, cur_first} + sbmd_pkg::sbmd_span(cur_mode.blk) - 7'h01);

    // refuse a group that the fitted variant does not have
    assign cur_fits = (cur_last <= {1'b0, sbmd_pkg::sbmd_max_ch(variant)});
    assign start_ok = start_req && (state == sbmd_pkg::ST_IDLE) && cur_mode.ok && cur_fits;

    ////////////////////////////////////////////////////////////////////////
    // sample acceptance

    // the fifo ready is also checked so no word can ever be dropped
    assign accept = SAMPLE_VALID && SAMPLE_READY && fifo_in_ready;
    assign finishing = accept && (word_cnt == 11'(run_words - 11'h001));
    assign next_scan = start_ok || ((state == sbmd_pkg::ST_SCAN) && !finishing && !abort_req);

    assign push_word.channel = SCAN_CHANNEL;
    assign push_word.data = SAMPLE_DATA;

    // ready comes from a flop, so it is dropped one word early; a full
    // buffer that software does not drain stalls the converter here
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SAMPLE_READY <= 1'b0;
        end else begin
            SAMPLE_READY <= next_scan && (fifo_level < sbmd_pkg::FIFO_STOP_LEVEL);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // scan sequencer

    // idle until a valid start, then walk the active channels
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= sbmd_pkg::ST_IDLE;
            SCAN_ACTIVE <= 1'b0;
        end else begin
            case (state)
                sbmd_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        state <= sbmd_pkg::ST_SCAN;
                        SCAN_ACTIVE <= 1'b1;
                    end
                end
                sbmd_pkg::ST_SCAN: begin
                    if (finishing || abort_req) begin
                        state <= sbmd_pkg::ST_IDLE;
                        SCAN_ACTIVE <= 1'b0;
                    end
                end
                default: begin
                    state <= sbmd_pkg::ST_IDLE;
                    SCAN_ACTIVE <= 1'b0;
                end
            endcase
        end
    end

    // scan parameters are latched at start
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            run_first <= '0;
            run_last <= '0;
            run_words <= '0;
        end else if (start_ok) begin
            run_first <= cur_first;
            run_last <= cur_last[5:0];
            run_words <= 11'(11'h001 << cur_mode.depth_log2);
        end
    end

    // channel pointer wraps from the last channel of the group to the first;
    // single channel modes keep pointing at one channel
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SCAN_CHANNEL <= '0;
        end else if (start_ok) begin
            SCAN_CHANNEL <= cur_first;
        end else if (accept) begin
            if (SCAN_CHANNEL == run_last) begin
                SCAN_CHANNEL <= run_first;
            end else begin
                SCAN_CHANNEL <= 6'(SCAN_CHANNEL + 6'h01);
            end
        end
    end

    // words collected in the current scan, kept after it ends
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            word_cnt <= '0;
        end else if (start_ok) begin
            word_cnt <= '0;
        end else if (accept) begin
            word_cnt <= 11'(word_cnt + 11'h001);
        end
    end

    // completion flag: set by a full buffer, cleared by the next start;
    // both cannot meet since start is only taken while idle
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SCAN_DONE <= 1'b0;
        end else if (finishing) begin
            SCAN_DONE <= 1'b1;
        end else if (start_ok) begin
            SCAN_DONE <= 1'b0;
        end
    end

    // start refusal reasons, refreshed by every start request while idle
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_err <= 1'b0;
            grp_err <= 1'b0;
        end else if (start_req && (state == sbmd_pkg::ST_IDLE)) begin
            mode_err <= !cur_mode.ok;
            grp_err <= cur_mode.ok && !cur_fits;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample buffer between the converter and the bus

    sbmd_fifo #(
        .WIDTH(sbmd_pkg::SAMPLE_W),
        .DEPTH(sbmd_pkg::FIFO_DEPTH),
        .LW(sbmd_pkg::FIFO_LW)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .in_valid(accept),
        .in_data(push_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(head_word),
        .out_ready(fifo_pop),
        .level(fifo_level)
    );

endmodule : sbmd_top

`default_nettype wire

//--- sim/sbmd_checker.sv
// port checker for the scan buffer mode decoder, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module sbmd_checker (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // sample stream and config fields
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_READY,
    input wire logic [5:0] SCAN_CHANNEL,
    input wire logic SCAN_ACTIVE,
    input wire logic SCAN_DONE,
    input wire logic CFG_OPTION,
    input wire logic [1:0] CFG_GAIN_LIKE_FIELD,
    input wire logic [1:0] CFG_SPEED
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    ////////////////////////////////////////
    logic take, hs, st;
    logic [15:0] cfg;
    logic [4:0] code;
    logic [5:0] low, first, last;
    logic [10:0] cnt, depth;
    int blk;
    assign take = PSEL && PENABLE && !PREADY;
    assign hs = SAMPLE_VALID && SAMPLE_READY && SCAN_ACTIVE;
    assign st = take && PWRITE && PADDR == 8'h04 && PWDATA[0] && !SCAN_ACTIVE;
    // shadow cfg; a start latches its mode and channel bits, so later writes cannot disturb the scan
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg <= 16'h0000;
            code <= 5'h00;
            low <= 6'h00;
        end else if (st) begin
            code <= cfg[15:11];
            low <= cfg[5:0];
        end else if (take && PWRITE && PADDR == 8'h00) begin
            cfg <= PWDATA[15:0];
        end
    end
    // words taken since start; 11 bits hold 1024
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) cnt <= 11'h000;
        else if (st) cnt <= 11'h000;
        else if (hs) cnt <= cnt + 11'h001;
    end
    // from 00111 up codes cycle single,8,16,32,64 with depth doubling
    always_comb begin
        blk = (code >= 5'h07) ? (int'(code) - 7) % 5 : int'(code) - 3;
        depth = (code >= 5'h07) ? 11'(1 << (6 + (int'(code) - 7) / 5)) : 11'h020;
        case (blk)
            1: first = {low[2:0], 3'h0};
            2: first = {low[2:1], 4'h0};
            3: first = {low[2], 5'h00};
            4: first = 6'h00;
            default: first = low;
        endcase
        last = (blk == 0) ? first : first + 6'((4 << blk) - 1);
    end
    ////////////////////////////////////////
    cfg_pass_a: assert property (take && PWRITE && PADDR == 8'h00 |=>
        {CFG_OPTION, CFG_GAIN_LIKE_FIELD, CFG_SPEED} == $past(PWDATA[10:6])) else $error("cfg fields wrong");
    ready_pulse_a: assert property (take |=> PREADY ##1 !PREADY) else $error("pready not one pulse");
    err_ready_a: assert property (PSLVERR |-> PREADY) else $error("pslverr without pready");
    ready_idle_a: assert property (!SCAN_ACTIVE && !$past(SCAN_ACTIVE) |-> !SAMPLE_READY)
        else $error("sample ready outside scan");
    first_ch_a: assert property ($rose(SCAN_ACTIVE) |-> SCAN_CHANNEL == first)
        else $error("wrong first channel");
    fixed_ch_a: assert property (hs && blk == 0 |=> !SCAN_ACTIVE || $stable(SCAN_CHANNEL))
        else $error("single channel moved");
    wrap_ch_a: assert property (hs && blk != 0 |=> !SCAN_ACTIVE || SCAN_CHANNEL ==
        ($past(SCAN_CHANNEL) == last ? first : $past(SCAN_CHANNEL) + 6'h01)) else $error("bad channel step");
    depth_a: assert property ($rose(SCAN_DONE) |-> cnt == depth)
        else $error("done at wrong word count");
    overrun_a: assert property (hs |-> cnt < depth) else $error("word taken past depth");
    single_c: cover property ($rose(SCAN_DONE) && blk == 0);
    full_c: cover property ($rose(SCAN_DONE) && blk == 4);
    err_c: cover property (PSLVERR);
endmodule : sbmd_checker

bind sbmd_top sbmd_checker chk_u (.*);

`default_nettype wire

//--- sim/sbmd_top_tb.sv
// self-checking bench for the scan buffer mode decoder
`timescale 1ns/1ps
`default_nettype none

module sbmd_top_tb;
    logic REF_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, SAMPLE_VALID = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic [15:0] SAMPLE_DATA = 16'h0000;
    logic PREADY, PSLVERR, SAMPLE_READY, SCAN_ACTIVE, SCAN_DONE, CFG_OPTION;
    logic [5:0] SCAN_CHANNEL;
    logic [1:0] CFG_GAIN_LIKE_FIELD, CFG_SPEED;
    int errors = 0, total_checks = 0, popped = 0;
    logic [32:0] eq[$], mq[$];
    logic [31:0] sq[$];

    always #5 REF_CLK = ~REF_CLK;

    sbmd_top dut_u (.*);

    ////////////////////////////////////////
    task automatic check(input string n, input logic [32:0] e, input logic [32:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic hang(input string n);
        errors++;
        $display("mismatch %s expected answer seen timeout", n);
        wrap_up();
    endtask : hang

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        t = 0;
        do begin
            @(posedge REF_CLK);
            t++;
        end while (PREADY !== 1'b1 && t < 50);
        if (PREADY !== 1'b1) hang("pready");
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
        eq.push_back(e & m);
        mq.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // random valid gaps; fifo back-pressure comes from the slow drain
    task automatic feed(input int n, input logic [5:0] f, input int b);
        int k, t;
        k = 0;
        for (t = 0; k < n && t < 40000; t++) begin
            @(posedge REF_CLK);
            if (SAMPLE_VALID && SAMPLE_READY === 1'b1) begin
                sq.push_back({10'h200, 6'(f + (b == 0 ? 0 : k % (4 << b))), SAMPLE_DATA});
                k++;
            end
            SAMPLE_VALID <= k < n && $urandom % 4 != 0;
            SAMPLE_DATA <= 16'($urandom);
        end
        if (k < n) hang("feed");
    endtask : feed

    function automatic int blk_of(input int c);
        return c >= 7 ? (c - 7) % 5 : c - 3;
    endfunction : blk_of

    function automatic int lg_of(input int c);
        return c >= 7 ? 6 + (c - 7) / 5 : 5;
    endfunction : lg_of

    function automatic logic [5:0] first_of(input int c, input logic [5:0] l);
        int b;
        b = blk_of(c);
        return b == 0 ? l : 6'((l & ((7 << (b - 1)) & 7)) << 3);
    endfunction : first_of

    ////////////////////////////////////////
    // read answers are matched in order against the driver's notes
    always @(posedge REF_CLK) begin
        if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) begin
            if (PADDR == sbmd_pkg::OFF_DATA && PRDATA[31]) begin
                check("sample", {1'b0, sq.pop_front()}, {PSLVERR, PRDATA});
                popped++;
            end else if (PADDR != sbmd_pkg::OFF_DATA) begin
                check("read", eq.pop_front(), {PSLVERR, PRDATA} & mq.pop_front());
            end
        end
    end

    initial begin
        int c, n, g;
        logic [5:0] l, f;
        logic [15:0] w;
        int sc[8] = '{17, 18, 24, 25, 31, 22, 27, 16};
        void'($urandom(74644));
        repeat (16) @(posedge REF_CLK);
        RESET_N <= 1'b1;
        @(posedge REF_CLK);
        // reset values and an unmapped word
        rd(sbmd_pkg::OFF_CFG, 33'h0, 33'h0ffff);
        rd(sbmd_pkg::OFF_CTRL, 33'h200, 33'h303);
        rd(8'h14, 33'h100000000, 33'h1ffffffff);
        // decoded depth, block and first channel for every supported code
        for (c = 3; c < 32; c++) begin
            w = {c[4:0], 11'($urandom)};
            apb(1'b1, sbmd_pkg::OFF_CFG, {16'h0, w});
            rd(sbmd_pkg::OFF_CFG, {17'h0, w}, 33'h0ffff);
            rd(sbmd_pkg::OFF_STATUS, {11'h0, first_of(c, w[5:0]), 5'h0, 3'(blk_of(c)), 4'(lg_of(c)), 4'h0},
                33'h03f07f0);
        end
        // unsupported codes, then a group the 16-channel variant lacks
        for (c = 0; c < 3; c++) begin
            apb(1'b1, sbmd_pkg::OFF_CFG, 32'(c) << 11);
            apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h201);
            rd(sbmd_pkg::OFF_STATUS, 33'h4, 33'h5);
        end
        apb(1'b1, sbmd_pkg::OFF_CFG, 32'h9002);
        apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h000);
        apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h001);
        rd(sbmd_pkg::OFF_STATUS, 33'h8, 33'hd);
        apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h200);
        // full scans; a mid-scan cfg write and start must change nothing
        foreach (sc[i]) begin
            c = sc[i];
            l = 6'($urandom);
            f = first_of(c, l);
            n = 1 << lg_of(c);
            apb(1'b1, sbmd_pkg::OFF_CFG, {16'h0, c[4:0], 5'($urandom), l});
            apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h201);
            popped = 0;
            fork
                feed(n, f, blk_of(c));
                begin
                    apb(1'b1, sbmd_pkg::OFF_CFG, 32'h0);
                    apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h201);
                    for (g = 0; popped < n && g < 9000; g++) apb(1'b0, sbmd_pkg::OFF_DATA, 32'h0);
                    if (popped < n) hang("drain");
                end
            join
            rd(sbmd_pkg::OFF_STATUS, 33'h2, 33'h3);
            rd(sbmd_pkg::OFF_COUNT, 33'(n), 33'h7ff);
        end
        // abort right after start: idle again, done cleared, nothing counted
        apb(1'b1, sbmd_pkg::OFF_CFG, 32'h8800);
        apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h201);
        apb(1'b1, sbmd_pkg::OFF_CTRL, 32'h202);
        rd(sbmd_pkg::OFF_STATUS, 33'h0, 33'h3);
        rd(sbmd_pkg::OFF_COUNT, 33'h0, 33'h7ff);
        wrap_up();
    end
endmodule : sbmd_top_tb

`default_nettype wire
